// ### logic/reset_cause_status.sv
// Summary of operation
// [RQ1] Flags for power-on, brown-out, watchdog and pin resets let software tell the last reset cause.
// [RQ2] The power-on flag in bit 1 reads 1 until a power-on reset drives it to 0.
// [RQ3] After a power-on reset software writes 1 to the power-on flag to arm it again.
// [RQ4] The brown-out flag in bit 0 reads 1 until a brown-out reset drives it to 0.
// [RQ5] After a brown-out reset software writes 1 to the brown-out flag to arm it again.
// [RQ6] A power-on reset leaves the brown-out flag undefined, so software sets it and checks it later.
// [RQ7] With brown-out detection disabled the brown-out flag carries no meaning.
// [RQ8] Bits 7 to 2 of the reset-cause register read as zero and ignore writes.
// [RQ9] Watchdog and pin resets leave both the power-on and brown-out flags unchanged.
module reset_cause_status
	import reset_cause_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic hsel,
	input wire reset_cause_pkg::word_t haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire reset_cause_pkg::word_t hwdata,
	input wire logic hready,
	output reset_cause_pkg::word_t hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic power_on_event,
	input wire logic brownout_event,
	input wire logic watchdog_reset,
	input wire logic external_reset_pin,
	input wire logic brownout_detect_enable,
	output logic irq
);

	// ********************************************************************
	// address decode helper
	// ********************************************************************
	function automatic logic hit(input word_t a, input word_t target);
		hit = (a == target);
	endfunction

	// ********************************************************************
	// bus phase state
	// ********************************************************************
	logic ph_valid_q;
	logic ph_valid_d;
	logic ph_write_q;
	logic ph_write_d;
	word_t ph_addr_q;
	word_t ph_addr_d;
	logic accept;

	// an address phase is taken when selected, ready and htrans is NONSEQ or SEQ (htrans[1] set)
	always_comb
	begin
		accept = hsel && hready && htrans[1];
		ph_valid_d = accept;
		ph_write_d = accept ? hwrite : 1'b0;
		ph_addr_d = accept ? haddr : ph_addr_q;
	end

	// register the address phase for use in the data phase
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			ph_valid_q <= 1'b0;
			ph_write_q <= 1'b0;
			ph_addr_q <= '0;
		end
		else if (clk_en)
		begin
			ph_valid_q <= ph_valid_d;
			ph_write_q <= ph_write_d;
			ph_addr_q <= ph_addr_d;
		end
	end

	// ********************************************************************
	// data-phase write strobes
	// ********************************************************************
	logic wr_cause;
	logic wr_status;
	logic wr_mask;

	// writes land in the data phase, when hwdata stands
	always_comb
	begin
		wr_cause = ph_valid_q && ph_write_q && hit(ph_addr_q, CAUSE_ADDR);
		wr_status = ph_valid_q && ph_write_q
			&& hit(ph_addr_q, IRQ_STATUS_ADDR);
		wr_mask = ph_valid_q && ph_write_q && hit(ph_addr_q, IRQ_MASK_ADDR);
	end

	// ********************************************************************
	// reset-cause flags
	// ********************************************************************
	cause_flags_t cause_q;
	cause_flags_t cause_d;
	logic brownout_seen;

	// software sets or clears, reset events force the flag low and win
	always_comb
	begin
		cause_d = cause_q;
		brownout_seen = brownout_event && brownout_detect_enable; // [RQ7]
		if (wr_cause)
			cause_d = hwdata[1:0]; // [RQ8]
		if (power_on_event)
			cause_d[POR_BIT] = 1'b0; // [RQ2]
		if (brownout_seen)
			cause_d[BROWNOUT_BIT] = 1'b0; // [RQ4]
		// a power-on alone keeps the brown-out flag as it stood [RQ6]
		// watchdog and pin resets do not reach these flags [RQ9]
	end

	// register the flags; reset leaves power-on flag low, brown-out high
	always_ff @(posedge clock)
	begin
		if (srst)
			cause_q <= CAUSE_RESET;
		else if (clk_en)
			cause_q <= cause_d;
	end

	// ********************************************************************
	// reset events into interrupt status and mask
	// ********************************************************************
	event_vec_t ev_pulse;
	event_vec_t ev_clear;
	event_vec_t status_d;
	event_vec_t status_q;
	event_vec_t mask_q;
	event_vec_t mask_d;

	// each observed reset source raises its own sticky bit
	always_comb
	begin
		ev_pulse = EVENT_RESET;
		ev_pulse[EV_POR] = power_on_event; // [RQ1]
		ev_pulse[EV_BROWNOUT] = brownout_seen; // [RQ1]
		ev_pulse[EV_WATCHDOG] = watchdog_reset; // [RQ1]
		ev_pulse[EV_EXT] = external_reset_pin; // [RQ1]
		ev_clear = wr_status ? hwdata[EVENT_W-1:0] : EVENT_RESET;
		mask_d = wr_mask ? hwdata[EVENT_W-1:0] : mask_q;
	end

	event_sticky sticky_bank (
		.clock(clock),
		.srst(srst),
		.clk_en(clk_en),
		.set_pulse(ev_pulse),
		.clear_mask(ev_clear),
		.status_d(status_d),
		.status_q(status_q)
	);

	// register the mask
	always_ff @(posedge clock)
	begin
		if (srst)
			mask_q <= EVENT_RESET;
		else if (clk_en)
			mask_q <= mask_d;
	end

	// ********************************************************************
	// read data, ready, response and interrupt outputs
	// ********************************************************************
	word_t rdata_d;
	logic irq_d;

	// read data built from next values, so a write just before is seen
	always_comb
	begin
		rdata_d = '0;
		if (accept && !hwrite)
		begin
			if (hit(haddr, CAUSE_ADDR))
				rdata_d = {30'h00000000, cause_d}; // [RQ8]
			else if (hit(haddr, IRQ_STATUS_ADDR))
				rdata_d = {28'h0000000, status_d};
			else if (hit(haddr, IRQ_MASK_ADDR))
				rdata_d = {28'h0000000, mask_d};
		end
		irq_d = |(status_d & mask_d);
	end

	// every output comes from a flip-flop; zero wait states, always okay
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			hrdata <= '0;
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
			irq <= 1'b0;
		end
		else if (clk_en)
		begin
			hrdata <= rdata_d;
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
			irq <= irq_d;
		end
	end

	// ********************************************************************
	// checks
	// ********************************************************************
	chk_por_flag_low: assert property ( // [RQ2]
		@(posedge clock) disable iff (srst)
		(clk_en && power_on_event) |=> (cause_q[POR_BIT] == 1'b0))
		else $error("power-on flag not low after power-on reset");

	chk_brownout_flag_low: assert property ( // [RQ4]
		@(posedge clock) disable iff (srst)
		(clk_en && brownout_event && brownout_detect_enable)
			|=> (cause_q[BROWNOUT_BIT] == 1'b0))
		else $error("brown-out flag not low after brown-out reset");

	chk_brownout_off_hold: assert property ( // [RQ7]
		@(posedge clock) disable iff (srst)
		(clk_en && brownout_event && !brownout_detect_enable && !wr_cause)
			|=> $stable(cause_q[BROWNOUT_BIT]))
		else $error("brown-out flag moved while detection disabled");

	chk_por_keeps_brownout: assert property ( // [RQ6]
		@(posedge clock) disable iff (srst)
		(clk_en && power_on_event && !brownout_event && !wr_cause)
			|=> $stable(cause_q[BROWNOUT_BIT]))
		else $error("power-on reset altered brown-out flag");

	chk_other_resets_keep: assert property ( // [RQ9]
		@(posedge clock) disable iff (srst)
		(clk_en && (watchdog_reset || external_reset_pin)
			&& !power_on_event && !brownout_event && !wr_cause)
			|=> $stable(cause_q))
		else $error("watchdog or pin reset altered cause flags");

	chk_upper_bits_zero: assert property ( // [RQ8]
		@(posedge clock) disable iff (srst)
		(clk_en && accept && !hwrite && hit(haddr, CAUSE_ADDR))
			|=> (hrdata[31:2] == 30'h00000000)
				&& (hrdata[1:0] == cause_q))
		else $error("cause read shows wrong bits");

	chk_cause_event_seen: assert property ( // [RQ1]
		@(posedge clock) disable iff (srst)
		(clk_en && external_reset_pin) |=> status_q[EV_EXT])
		else $error("pin reset not recorded in status");

	chk_irq_follows_status: assert property ( // [RQ1]
		@(posedge clock) disable iff (srst)
		clk_en |=> (irq == (|(status_q & mask_q))))
		else $error("interrupt line does not follow status and mask");

	chk_sw_rearm: assert property ( // [RQ3]
		@(posedge clock) disable iff (srst)
		(clk_en && wr_cause && hwdata[POR_BIT] && !power_on_event)
			|=> cause_q[POR_BIT])
		else $error("power-on flag not re-armed by software");

endmodule // reset_cause_status

// ### logic/reset_cause_pkg.sv
package reset_cause_pkg;

	// ********************************************************************
	// bus word and field types
	// ********************************************************************
	typedef logic [31:0] word_t;
	typedef logic [3:0] event_vec_t;
	typedef logic [1:0] cause_flags_t;

	localparam int EVENT_W = 4;

	// ********************************************************************
	// register indices and byte addresses (byte address = 4 * index)
	// ********************************************************************
	localparam logic [7:0] CAUSE_IDX = 8'h8e;
	localparam logic [7:0] IRQ_STATUS_IDX = 8'h90;
	localparam logic [7:0] IRQ_MASK_IDX = 8'h91;
	localparam word_t CAUSE_ADDR = {22'h000000, CAUSE_IDX, 2'h0};
	localparam word_t IRQ_STATUS_ADDR = {22'h000000, IRQ_STATUS_IDX, 2'h0};
	localparam word_t IRQ_MASK_ADDR = {22'h000000, IRQ_MASK_IDX, 2'h0};

	// ********************************************************************
	// reset-cause flag positions and value after reset
	// ********************************************************************
	localparam int BROWNOUT_BIT = 0;
	localparam int POR_BIT = 1;
	localparam cause_flags_t CAUSE_RESET = 2'h1;

	// ********************************************************************
	// event positions in interrupt status and mask
	// ********************************************************************
	localparam int EV_POR = 0;
	localparam int EV_BROWNOUT = 1;
	localparam int EV_WATCHDOG = 2;
	localparam int EV_EXT = 3;
	localparam event_vec_t EVENT_RESET = 4'h0;

	// ********************************************************************
	// bus encodings
	// ********************************************************************
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

endpackage

// ### logic/event_sticky.sv
module event_sticky
	import reset_cause_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic clk_en,
	input wire reset_cause_pkg::event_vec_t set_pulse,
	input wire reset_cause_pkg::event_vec_t clear_mask,
	output reset_cause_pkg::event_vec_t status_d,
	output reset_cause_pkg::event_vec_t status_q
);

	// ********************************************************************
	// sticky bits: write one to clear, a new event wins over the clear
	// ********************************************************************
	always_comb
	begin
		status_d = (status_q & ~clear_mask) | set_pulse;
	end

	// register the sticky bits, frozen while clk_en is low
	always_ff @(posedge clock)
	begin
		if (srst)
			status_q <= EVENT_RESET;
		else if (clk_en)
			status_q <= status_d;
	end

	chk_set_beats_clear: assert property ( // [RQ1]
		@(posedge clock) disable iff (srst)
		(clk_en && (set_pulse != 4'h0)) |=>
			((status_q & $past(set_pulse)) == $past(set_pulse)))
		else $error("event lost against a simultaneous clear");

endmodule // event_sticky

// ### dv/reset_cause_status_bench.sv
module reset_cause_status_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import reset_cause_pkg::*;

	// ****************************************
	// stimulus signals and design instance
	// ****************************************
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic clk_en = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	word_t haddr = 32'h0;
	word_t hwdata = 32'h0;
	logic [3:0] ev = 4'h0;
	logic det_en = 1'b1;
	logic hready;
	logic hreadyout;
	logic hresp;
	logic irq;
	word_t hrdata;
	word_t rd;
	int error_cnt = 0;
	int check_count = 0;
	int cyc = 0;

	// the single slave drives the bus ready
	assign hready = hreadyout;

	reset_cause_status reset_cause_status_inst (
		.clock(clock),
		.srst(srst),
		.clk_en(clk_en),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.power_on_event(ev[0]),
		.brownout_event(ev[1]),
		.watchdog_reset(ev[2]),
		.external_reset_pin(ev[3]),
		.brownout_detect_enable(det_en),
		.irq(irq)
	);

	// 25 MHz clock
	always #20 clock = ~clock;

	// ****************************************
	// tasks
	// ****************************************
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input string what, input word_t seen,
		input word_t exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one single transfer; called just after a rising edge
	task automatic bus(input logic wr, input word_t a, input word_t d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		do @(posedge clock); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input word_t a, input word_t d);
		bus(1'b1, a, d);
	endtask

	task automatic rd_chk(input string what, input word_t a, input word_t e);
		bus(1'b0, a, 32'h0);
		check(what, rd, e);
	endtask

	// one-cycle event pulse on line i
	task automatic pulse(input int i);
		ev[i] <= 1'b1;
		@(posedge clock);
		ev <= 4'h0;
		@(posedge clock);
	endtask

	task automatic irq_chk(input logic e);
		@(posedge clock);
		check("irq", {31'h0, irq}, {31'h0, e});
	endtask

	// ****************************************
	// hang guard and test sequence
	// ****************************************
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			error_cnt++;
			print_verdict;
		end
	end

	initial
	begin
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		rd_chk("cause reset", CAUSE_ADDR, {30'h0, CAUSE_RESET});
		check("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
		check("hreadyout", {31'h0, hreadyout}, 32'h1);
		rd_chk("status reset", IRQ_STATUS_ADDR, 32'h0);
		rd_chk("mask reset", IRQ_MASK_ADDR, 32'h0);
		wr(CAUSE_ADDR, 32'hffffffff);
		rd_chk("cause upper bits", CAUSE_ADDR, 32'h3);
		pulse(0);
		rd_chk("cause power-on", CAUSE_ADDR, 32'h1);
		rd_chk("status power-on", IRQ_STATUS_ADDR, 32'h1);
		wr(CAUSE_ADDR, 32'h3);
		rd_chk("cause rearmed", CAUSE_ADDR, 32'h3);
		pulse(1);
		rd_chk("cause brownout", CAUSE_ADDR, 32'h2);
		wr(CAUSE_ADDR, 32'h3);
		rd_chk("cause rearm brownout", CAUSE_ADDR, 32'h3);
		// brown-out with detection switched off is ignored
		det_en <= 1'b0;
		pulse(1);
		det_en <= 1'b1;
		rd_chk("cause detect off", CAUSE_ADDR, 32'h3);
		pulse(2);
		pulse(3);
		rd_chk("cause other resets", CAUSE_ADDR, 32'h3);
		rd_chk("status all", IRQ_STATUS_ADDR, 32'hf);
		irq_chk(1'b0);
		wr(IRQ_MASK_ADDR, 32'h4);
		irq_chk(1'b1);
		rd_chk("mask", IRQ_MASK_ADDR, 32'h4);
		wr(IRQ_STATUS_ADDR, 32'h4);
		irq_chk(1'b0);
		rd_chk("status cleared", IRQ_STATUS_ADDR, 32'hb);
		// unmapped place reads zero and ignores writes
		wr(32'h00000100, 32'hffffffff);
		rd_chk("unmapped", 32'h00000100, 32'h0);
		rd_chk("cause kept", CAUSE_ADDR, 32'h3);
		// frozen clock enable takes no event
		clk_en <= 1'b0;
		pulse(0);
		clk_en <= 1'b1;
		rd_chk("cause frozen", CAUSE_ADDR, 32'h3);
		// power-on event on the write edge wins over the write
		fork
			wr(CAUSE_ADDR, 32'h3);
			begin
				@(posedge clock);
				ev <= 4'h1;
				@(posedge clock);
				ev <= 4'h0;
			end
		join
		rd_chk("cause event wins", CAUSE_ADDR, 32'h1);
		// a pending unmasked event holds irq high before the reset
		pulse(2);
		irq_chk(1'b1);
		// mid-run reset reloads reset values: power-on flag low, brown-out flag high, status and mask clear
		wr(CAUSE_ADDR, 32'h2);
		srst <= 1'b1;
		@(posedge clock);
		srst <= 1'b0;
		rd_chk("cause second reset", CAUSE_ADDR, 32'h1);
		rd_chk("status second reset", IRQ_STATUS_ADDR, 32'h0);
		rd_chk("mask second reset", IRQ_MASK_ADDR, 32'h0);
		irq_chk(1'b0);
		print_verdict;
	end

endmodule // reset_cause_status_bench
